// File: rtl/rts_pkg.sv
// Package of constants and carrier types for the reload timer with square output
package rts_pkg;
    // Bus and prescaler geometry
    localparam int          ADDR_W         = 18;
    localparam int          DATA_W         = 32;
    localparam int          PRE_W          = 13;

    // Register indices; byte address is four times the index
    localparam logic [15:0] IDX_TIMER_MODE = 16'hFFC8;
    localparam logic [15:0] IDX_COUNT      = 16'hFFC9;
    localparam logic [15:0] IDX_PIN_CTRL   = 16'hFFEE;
    localparam logic [15:0] IDX_IRQ_REQ    = 16'hFFF0;
    localparam logic [15:0] IDX_IRQ_EN     = 16'hFFF1;
    localparam logic [15:0] IDX_PORT_FUNC  = 16'hFFF2;

    // Field positions
    localparam int          TMC_MODE_BIT   = 7;
    localparam int          PIN_SEL_BIT    = 7;
    localparam int          PIN_ON_BIT     = 6;
    localparam int          PIN_FIXED_RATE_PICK_BIT   = 5;
    localparam int          PIN_VAR_BIT    = 4;
    localparam int          PFC_IRQ_BIT    = 5;

    // Reset values and constant bit patterns
    localparam logic [7:0]  TMC_RESET      = 8'h78;
    localparam logic [7:0]  TMC_ONES       = 8'h78;
    localparam logic [7:0]  PIN_RESET      = 8'h0F;
    localparam logic [7:0]  PIN_ONES       = 8'h0F;
    localparam logic [7:0]  COUNT_RESET    = 8'h00;
    localparam logic [7:0]  COUNT_TOP      = 8'hFF;

    // Prescaler bits that give the fixed square waves (half periods 1024 and 512)
    localparam int          FIX_SLOW_BIT   = 10;
    localparam int          FIX_FAST_BIT   = 9;

    // Prescaler division exponents per tap code 000..111
    localparam logic [3:0]  TAP_EXP0       = 4'hD;
    localparam logic [3:0]  TAP_EXP1       = 4'hC;
    localparam logic [3:0]  TAP_EXP2       = 4'hB;
    localparam logic [3:0]  TAP_EXP3       = 4'h9;
    localparam logic [3:0]  TAP_EXP4       = 4'h8;
    localparam logic [3:0]  TAP_EXP5       = 4'h7;
    localparam logic [3:0]  TAP_EXP6       = 4'h5;
    localparam logic [3:0]  TAP_EXP7       = 4'h3;

    // APB request from the master
    typedef struct packed {
        logic              psel;
        logic              penable;
        logic              pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [DATA_W-1:0] pwdata;
    } rts_apb_req_t;

    // APB answer to the master
    typedef struct packed {
        logic              pready;
        logic              pslverr;
        logic [DATA_W-1:0] prdata;
    } rts_apb_rsp_t;

    // Shared pin and its function indicators
    typedef struct packed {
        logic              level;
        logic              oe;
        logic              gpio_mode;
        logic              irq_input_mode;
    } rts_pin_t;
endpackage

// File: rtl/rts_timer.sv
// Eight-bit reload timer with prescaler taps, overflow flag and square wave pin, APB slave
// Contract
// - Mode bit 0 interval, 1 auto-reload
// - Three-bit field selects one of eight taps
// - Mode register bits 6..3 read one
// - Counter increments per tick, readable anytime
// - Overflow past FF sets request flag
// - One address: read counter, write reload
// - Reload write also loads counter immediately
// - Auto-reload mode reloads counter on overflow
// - Interval mode wraps to zero, keeps counting
// - Reset: counter zero, interval, counting at once
// - Interrupt only when flag and enable set
// - Irq select makes input; else GPIO unless output selected
// - Output selected but off drives low
// - Fixed square wave phi/2048 or phi/1024
// - Variable mode toggles pin on overflow
// - Pin control bits 3..0 read one
// - Square waves have fifty percent duty
module rts_timer (
    // Clock and reset
    input  wire logic                  clock_in,
    input  wire logic                  reset_n_in,
    // APB slave
    input  wire rts_pkg::rts_apb_req_t apb_in,
    output      rts_pkg::rts_apb_rsp_t apb_out,
    // Interrupt request to the CPU
    output      logic                  overflow_irq_out,
    // Shared pin
    output      rts_pkg::rts_pin_t     shared_output_pin_out
);
    import rts_pkg::*;

    // All state of the block
    typedef struct packed {
        logic [PRE_W-1:0]  pre;
        logic [7:0]        count_value;
        logic [7:0]        reload_value;
        logic              reload_mode_select;
        logic [2:0]        prescaler_tap_select;
        logic [3:0]        pin_ctrl;
        logic              pin_irq_select;
        logic              overflow_request_flag;
        logic              overflow_irq_enable;
        logic              toggle;
        rts_pin_t          pin;
        logic [DATA_W-1:0] prdata;
        logic              pslverr;
    } rts_state_t;

    rts_state_t        state_q;
    rts_state_t        state_d;
    logic              setup_rd;
    logic              access_wr;
    logic              tick;
    logic              overflow;
    logic              wr_count;
    logic [PRE_W-1:0]  tap_mask;

    // The tap table and wave bits assume a thirteen-bit prescaler
    if (PRE_W != 13) begin : g_pre_check
        $error("prescaler width cannot serve the tap table");
    end

    // Byte address of a register index
    function automatic logic [ADDR_W-1:0] byte_addr(input logic [15:0] idx);
        byte_addr = {idx, 2'b00};
    endfunction

    // Mask of prescaler bits that must all be one for a tap pulse
    function automatic logic [PRE_W-1:0] mask_of(input logic [2:0] sel);
        logic [3:0] e;
        e = TAP_EXP0;
        case (sel)
            3'h0:    e = TAP_EXP0;
            3'h1:    e = TAP_EXP1;
            3'h2:    e = TAP_EXP2;
            3'h3:    e = TAP_EXP3;
            3'h4:    e = TAP_EXP4;
            3'h5:    e = TAP_EXP5;
            3'h6:    e = TAP_EXP6;
            3'h7:    e = TAP_EXP7;
            default: e = TAP_EXP0;
        endcase
        mask_of = PRE_W'((14'h0001 << e) - 14'h0001);
    endfunction

    // Decode of a mapped address
    function automatic logic mapped(input logic [ADDR_W-1:0] a);
        mapped = (a == byte_addr(IDX_TIMER_MODE)) || (a == byte_addr(IDX_COUNT)) ||
                 (a == byte_addr(IDX_PIN_CTRL)) || (a == byte_addr(IDX_IRQ_REQ)) ||
                 (a == byte_addr(IDX_IRQ_EN)) || (a == byte_addr(IDX_PORT_FUNC));
    endfunction

    // Bus phase and counter events
    always_comb begin
        setup_rd  = apb_in.psel && !apb_in.penable;
        access_wr = apb_in.psel && apb_in.penable && apb_in.pwrite;
        wr_count  = access_wr && (apb_in.paddr == byte_addr(IDX_COUNT));
        tap_mask  = mask_of(state_q.prescaler_tap_select);
        tick      = ((state_q.pre & tap_mask) == tap_mask);
        overflow  = tick && (state_q.count_value == COUNT_TOP) && !wr_count;
    end

    // Next state
    always_comb begin
        state_d     = state_q;
        state_d.pre = state_q.pre + PRE_W'(1);

        // Counting and reload
        if (wr_count) begin
            state_d.reload_value = apb_in.pwdata[7:0];
            state_d.count_value  = apb_in.pwdata[7:0];
        end else if (overflow) begin
            if (state_q.reload_mode_select) begin
                state_d.count_value = state_q.reload_value;
            end else begin
                state_d.count_value = COUNT_RESET;
            end
        end else if (tick) begin
            state_d.count_value = state_q.count_value + 8'h01;
        end

        // Register writes
        if (access_wr) begin
            if (apb_in.paddr == byte_addr(IDX_TIMER_MODE)) begin
                state_d.reload_mode_select   = apb_in.pwdata[TMC_MODE_BIT];
                state_d.prescaler_tap_select = apb_in.pwdata[2:0];
            end
            if (apb_in.paddr == byte_addr(IDX_PIN_CTRL)) begin
                state_d.pin_ctrl = apb_in.pwdata[7:4];
            end
            if (apb_in.paddr == byte_addr(IDX_PORT_FUNC)) begin
                state_d.pin_irq_select = apb_in.pwdata[PFC_IRQ_BIT];
            end
            if (apb_in.paddr == byte_addr(IDX_IRQ_EN)) begin
                state_d.overflow_irq_enable = apb_in.pwdata[0];
            end
            if (apb_in.paddr == byte_addr(IDX_IRQ_REQ) && !apb_in.pwdata[0]) begin
                state_d.overflow_request_flag = 1'b0;
            end
        end
        // Setting wins over a clear in the same cycle
        if (overflow) begin
            state_d.overflow_request_flag = 1'b1;
        end

        // Overflow toggle flip-flop, held low outside variable mode
        if (!(state_q.pin_ctrl[PIN_VAR_BIT-4] && state_q.pin_ctrl[PIN_ON_BIT-4])) begin
            state_d.toggle = 1'b0;
        end else if (overflow) begin
            state_d.toggle = !state_q.toggle;
        end

        // Pin function and level
        state_d.pin.irq_input_mode = state_d.pin_irq_select;
        state_d.pin.gpio_mode      = !state_d.pin_irq_select && !state_d.pin_ctrl[PIN_SEL_BIT-4];
        state_d.pin.oe             = !state_d.pin_irq_select && state_d.pin_ctrl[PIN_SEL_BIT-4];
        if (!state_d.pin.oe || !state_d.pin_ctrl[PIN_ON_BIT-4]) begin
            state_d.pin.level = 1'b0;
        end else if (state_d.pin_ctrl[PIN_VAR_BIT-4]) begin
            state_d.pin.level = state_d.toggle;
        end else if (state_d.pin_ctrl[PIN_FIXED_RATE_PICK_BIT-4]) begin
            state_d.pin.level = state_d.pre[FIX_FAST_BIT];
        end else begin
            state_d.pin.level = state_d.pre[FIX_SLOW_BIT];
        end

        // Read data captured in the setup phase, shown in the access phase
        if (setup_rd) begin
            state_d.pslverr = !mapped(apb_in.paddr);
            state_d.prdata  = '0;
            if (!apb_in.pwrite) begin
                case (apb_in.paddr)
                    byte_addr(IDX_TIMER_MODE): state_d.prdata[7:0] = TMC_ONES |
                        {state_q.reload_mode_select, 4'h0, state_q.prescaler_tap_select};
                    byte_addr(IDX_COUNT):      state_d.prdata[7:0] = state_q.count_value;
                    byte_addr(IDX_PIN_CTRL):   state_d.prdata[7:0] = PIN_ONES |
                        {state_q.pin_ctrl, 4'h0};
                    byte_addr(IDX_IRQ_REQ):    state_d.prdata[0]   = state_q.overflow_request_flag;
                    byte_addr(IDX_IRQ_EN):     state_d.prdata[0]   = state_q.overflow_irq_enable;
                    byte_addr(IDX_PORT_FUNC):  state_d.prdata[PFC_IRQ_BIT] = state_q.pin_irq_select;
                    default:                   state_d.prdata      = '0;
                endcase
            end
        end
    end

    // State register; counting starts straight out of reset
    always_ff @(posedge clock_in) begin
        if (!reset_n_in) begin
            state_q                       <= '0;
            state_q.count_value           <= COUNT_RESET;
            state_q.reload_value          <= COUNT_RESET;
            state_q.reload_mode_select    <= TMC_RESET[TMC_MODE_BIT];
            state_q.prescaler_tap_select  <= TMC_RESET[2:0];
            state_q.pin_ctrl              <= PIN_RESET[7:4];
            state_q.pin.gpio_mode         <= 1'b1;
        end else begin
            state_q <= state_d;
        end
    end

    // Outputs
    always_comb begin
        apb_out.pready        = 1'b1;
        apb_out.pslverr       = state_q.pslverr;
        apb_out.prdata        = state_q.prdata;
        overflow_irq_out      = state_q.overflow_request_flag && state_q.overflow_irq_enable;
        shared_output_pin_out = state_q.pin;
    end

    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (!reset_n_in);

    a_count_step: assert property (tick && !wr_count && state_q.count_value != COUNT_TOP
        |=> state_q.count_value == $past(state_q.count_value) + 8'h01)
        else $error("counter did not step by one on a tick");
    a_count_hold: assert property (!tick && !wr_count |=> $stable(state_q.count_value))
        else $error("counter moved without a tick");
    a_overflow_flag: assert property (overflow |=> overflow_irq_out == state_q.overflow_irq_enable
        && state_q.overflow_request_flag)
        else $error("overflow did not set the flag");
    a_wrap_zero: assert property (overflow && !state_q.reload_mode_select
        |=> state_q.count_value == 8'h00)
        else $error("interval mode did not wrap to zero");
    a_auto_reload: assert property (overflow && state_q.reload_mode_select
        |=> state_q.count_value == $past(state_q.reload_value))
        else $error("auto-reload did not load the reload value");
    a_write_loads: assert property (wr_count
        |=> state_q.count_value == $past(apb_in.pwdata[7:0]) && state_q.reload_value == state_q.count_value)
        else $error("reload write did not load the counter");
    a_tick_single: assert property (tick |=> !tick)
        else $error("tap enable lasted more than one cycle");
    a_mode_ones: assert property (setup_rd && !apb_in.pwrite && apb_in.paddr == byte_addr(IDX_TIMER_MODE)
        |=> apb_out.prdata[6:3] == 4'hF)
        else $error("mode register reserved bits not one");
    a_pin_ones: assert property (setup_rd && !apb_in.pwrite && apb_in.paddr == byte_addr(IDX_PIN_CTRL)
        |=> apb_out.prdata[3:0] == 4'hF)
        else $error("pin control reserved bits not one");
    a_irq_input: assert property (state_q.pin_irq_select |-> !shared_output_pin_out.oe
        && shared_output_pin_out.irq_input_mode)
        else $error("irq select did not release the pin");
    a_low_when_off: assert property (!state_q.pin_irq_select && state_q.pin_ctrl[3] && !state_q.pin_ctrl[2]
        |-> shared_output_pin_out.oe && !shared_output_pin_out.level)
        else $error("pin not driven low while output off");
    a_toggle_ovf: assert property (overflow && state_q.pin_ctrl[2] && state_q.pin_ctrl[0]
        && !(access_wr && apb_in.paddr == byte_addr(IDX_PIN_CTRL)) |=> state_q.toggle != $past(state_q.toggle))
        else $error("overflow did not toggle the pin");

    // Further checks on taps, flag, bus and pin

    // Fastest tap pulses once in eight cycles
    a_tap_fast: assert property (state_q.prescaler_tap_select == 3'h7
        |-> tick == (state_q.pre[2:0] == 3'h7))
        else $error("fastest tap pulse misplaced");

    // Slowest tap pulses once per prescaler turn
    a_tap_slow: assert property (state_q.prescaler_tap_select == 3'h0
        |-> tick == (&state_q.pre))
        else $error("slowest tap pulse misplaced");

    // Middle tap divides by five hundred twelve
    a_tap_mid: assert property (state_q.prescaler_tap_select == 3'h3
        |-> tick == (&state_q.pre[8:0]))
        else $error("middle tap pulse misplaced");

    // Prescaler never stops
    a_pre_runs: assert property (1'b1
        |=> state_q.pre == $past(state_q.pre) + PRE_W'(1))
        else $error("prescaler did not advance");

    // Counter and mode cleared by reset
    a_reset_zero: assert property ($rose(reset_n_in)
        |-> state_q.count_value == COUNT_RESET && !state_q.reload_mode_select)
        else $error("reset left counter or mode set");

    // Tap field cleared by reset
    a_reset_tap: assert property ($rose(reset_n_in)
        |-> state_q.prescaler_tap_select == 3'h0)
        else $error("reset left tap field set");

    // Counting starts with no start command
    a_reset_count: assert property ($rose(reset_n_in)
        |=> state_q.pre == PRE_W'(1))
        else $error("prescaler idle after reset");

    // No request while disabled
    a_irq_masked: assert property (!state_q.overflow_irq_enable
        |-> !overflow_irq_out)
        else $error("request shown while disabled");

    // No request without the flag
    a_irq_noflag: assert property (!state_q.overflow_request_flag
        |-> !overflow_irq_out)
        else $error("request shown without flag");

    // Flag is set only by an overflow
    a_flag_only: assert property (!state_q.overflow_request_flag && !overflow
        |=> !state_q.overflow_request_flag)
        else $error("flag set without overflow");

    // Flag stays until software clears it
    a_flag_sticky: assert property (state_q.overflow_request_flag
        && !(access_wr && apb_in.paddr == byte_addr(IDX_IRQ_REQ)) |=> state_q.overflow_request_flag)
        else $error("flag dropped by itself");

    // Shared address reads the counter
    a_read_count: assert property (setup_rd && !apb_in.pwrite && apb_in.paddr == byte_addr(IDX_COUNT)
        |=> apb_out.prdata[7:0] == $past(state_q.count_value))
        else $error("count read wrong value");

    // Upper read bits are zero
    a_read_upper: assert property (setup_rd && !apb_in.pwrite
        |=> apb_out.prdata[31:8] == 24'h0)
        else $error("upper read bits not zero");

    // Reload register changes only by a write
    a_reload_kept: assert property (!wr_count
        |=> $stable(state_q.reload_value))
        else $error("reload value changed without write");

    // Mode and tap fields take the written value
    a_mode_write: assert property (access_wr && apb_in.paddr == byte_addr(IDX_TIMER_MODE)
        |=> state_q.reload_mode_select == $past(apb_in.pwdata[TMC_MODE_BIT])
        && state_q.prescaler_tap_select == $past(apb_in.pwdata[2:0]))
        else $error("mode write not stored");

    // Pin control takes the written upper bits
    a_pin_write: assert property (access_wr && apb_in.paddr == byte_addr(IDX_PIN_CTRL)
        |=> state_q.pin_ctrl == $past(apb_in.pwdata[7:4]))
        else $error("pin control write not stored");

    // Plain port when nothing selected
    a_gpio_mode: assert property (!state_q.pin_irq_select && !state_q.pin_ctrl[3]
        |-> shared_output_pin_out.gpio_mode && !shared_output_pin_out.oe)
        else $error("pin not a plain port");

    // Slow fixed wave follows its prescaler bit
    a_fixed_slow: assert property (state_q.pin.oe && state_q.pin_ctrl[2:0] == 3'b100
        |-> state_q.pin.level == state_q.pre[FIX_SLOW_BIT])
        else $error("slow fixed wave wrong");

    // Fast fixed wave follows its prescaler bit
    a_fixed_fast: assert property (state_q.pin.oe && state_q.pin_ctrl[2:0] == 3'b110
        |-> state_q.pin.level == state_q.pre[FIX_FAST_BIT])
        else $error("fast fixed wave wrong");

    // Variable wave shows the toggle
    a_var_level: assert property (state_q.pin.oe && state_q.pin_ctrl[2] && state_q.pin_ctrl[0]
        |-> state_q.pin.level == state_q.toggle)
        else $error("variable wave not the toggle");

    // Toggle holds between overflows
    a_toggle_hold: assert property (state_q.pin_ctrl[2] && state_q.pin_ctrl[0] && !overflow
        |=> $stable(state_q.toggle))
        else $error("toggle moved without overflow");

    // Slow wave edges fall on half-period bounds
    a_duty_slow: assert property (state_q.pin.oe && state_q.pin_ctrl[2:0] == 3'b100
        && $changed(state_q.pin.level) && $stable(state_q.pin_ctrl) && $stable(state_q.pin.oe)
        |-> state_q.pre[9:0] == 10'h000)
        else $error("slow wave edge off its bound");

    // Fast wave edges fall on half-period bounds
    a_duty_fast: assert property (state_q.pin.oe && state_q.pin_ctrl[2:0] == 3'b110
        && $changed(state_q.pin.level) && $stable(state_q.pin_ctrl) && $stable(state_q.pin.oe)
        |-> state_q.pre[8:0] == 9'h000)
        else $error("fast wave edge off its bound");

    // Unmapped address answers with an error
    a_unmapped_err: assert property (setup_rd && !mapped(apb_in.paddr)
        |=> apb_out.pslverr)
        else $error("unmapped address not refused");
endmodule

// File: tb/rts_timer_tb.sv
// Self-checking bench for the reload timer with square output
module rts_timer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import rts_pkg::*;

    // Design connections and bench state
    logic         clock_in;
    logic         reset_n_in;
    rts_apb_req_t apb_in;
    rts_apb_rsp_t apb_out;
    logic         overflow_irq_out;
    rts_pin_t     pin;
    int           failures;
    int           n_tests;
    int           cyc;
    int           t0;
    int           t_mark;
    int           hi;
    int           lo;
    logic [31:0]  lfsr_q;
    logic [31:0]  rd;
    logic         err;

    rts_timer rts_timer_i (
        .clock_in              (clock_in),
        .reset_n_in            (reset_n_in),
        .apb_in                (apb_in),
        .apb_out               (apb_out),
        .overflow_irq_out      (overflow_irq_out),
        .shared_output_pin_out (pin)
    );

    // Clock, cycle count and hang guard
    always #10 clock_in = ~clock_in;
    always @(posedge clock_in) begin
        cyc <= cyc + 1;
        if (cyc == 80000) begin
            failures++;
            end_of_test();
        end
    end

    // Expected values
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [31:0] exp_tmc(input logic [7:0] v);
        return {24'h0, (v & 8'h87) | 8'h78};
    endfunction
    function automatic logic [31:0] exp_pin(input logic [7:0] v);
        return {24'h0, (v & 8'hF0) | 8'h0F};
    endfunction
    function automatic int tap_div(input int t);
        int d[8] = '{8192, 4096, 2048, 512, 256, 128, 32, 8};
        return d[t];
    endfunction

    // One APB transfer; request held until pready is seen
    task automatic apb(input logic wr, input logic [15:0] idx, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clock_in);
        apb_in <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: {idx, 2'b00}, pwdata: wd};
        @(posedge clock_in);
        apb_in.penable <= 1'b1;
        do begin
            @(posedge clock_in);
            n++;
        end while (apb_out.pready !== 1'b1 && n < 16);
        if (n >= 16) failures++;
        rd = apb_out.prdata;
        err = apb_out.pslverr;
        apb_in.psel <= 1'b0;
        apb_in.penable <= 1'b0;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic rdc(input logic [15:0] idx, input logic [31:0] mask, input logic [31:0] exp);
        apb(1'b0, idx, 32'h0);
        chk(rd & mask, exp);
    endtask

    // Waits for the irq (lvl 0) or pin level (lvl 1) to show v
    task automatic wait_sig(input bit lvl, input logic v);
        int n;
        n = 0;
        do begin
            @(posedge clock_in);
            #1;
            n++;
        end while ((lvl ? pin.level : overflow_irq_out) !== v && n < 9000);
        if (n >= 9000) failures++;
        t_mark = cyc;
    endtask

    // High and low time of the pin
    task automatic halves();
        wait_sig(1, 1'b0);
        wait_sig(1, 1'b1);
        t0 = t_mark;
        wait_sig(1, 1'b0);
        hi = t_mark - t0;
        t0 = t_mark;
        wait_sig(1, 1'b1);
        lo = t_mark - t0;
    endtask

    task automatic settle();
        repeat (2) @(posedge clock_in);
        #1;
    endtask

    task automatic end_of_test();
        $display("tests %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // Main sequence
    initial begin
        clock_in = 1'b0;
        reset_n_in = 1'b0;
        apb_in = '0;
        failures = 0;
        n_tests = 0;
        cyc = 0;
        lfsr_q = 32'hA4B2;
        repeat (16) @(posedge clock_in);
        reset_n_in <= 1'b1;
        rdc(IDX_TIMER_MODE, 32'hFF, 32'h78);
        rdc(IDX_COUNT, 32'hFF, 32'h00);
        rdc(IDX_PIN_CTRL, 32'hFF, 32'h0F);
        chk({pin.gpio_mode, pin.oe, overflow_irq_out}, 3'b100);
        $display("test reset done");
        for (int i = 0; i < 4; i++) begin
            lfsr_q = lfsr_next(lfsr_q);
            apb(1'b1, IDX_TIMER_MODE, lfsr_q);
            rdc(IDX_TIMER_MODE, 32'hFF, exp_tmc(lfsr_q[7:0]));
            apb(1'b1, IDX_PIN_CTRL, lfsr_q >> 8);
            rdc(IDX_PIN_CTRL, 32'hFF, exp_pin(lfsr_q[15:8]));
            apb(1'b1, IDX_TIMER_MODE, {24'h0, lfsr_q[16], 7'h00});
            apb(1'b1, IDX_COUNT, lfsr_q >> 20);
            rdc(IDX_COUNT, 32'hFFFFFFFF, {24'h0, lfsr_q[27:20]});
            rdc(IDX_COUNT, 32'hFFFFFFFF, {24'h0, lfsr_q[27:20]});
        end
        apb(1'b0, 16'h0000, 32'h0);
        chk({rd[30:0], err}, 32'h1);
        $display("test registers done");
        apb(1'b1, IDX_IRQ_EN, 32'h1);
        apb(1'b1, IDX_PIN_CTRL, 32'h0);
        for (int t = 7; t >= 0; t--) begin
            apb(1'b1, IDX_TIMER_MODE, t);
            apb(1'b1, IDX_IRQ_REQ, 32'h0);
            apb(1'b1, IDX_COUNT, 32'hFF);
            wait_sig(0, 1'b1);
            t0 = t_mark;
            apb(1'b1, IDX_COUNT, 32'hFF);
            apb(1'b1, IDX_IRQ_REQ, 32'h0);
            wait_sig(0, 1'b1);
            chk(t_mark - t0, tap_div(t));
            rdc(IDX_COUNT, 32'hFF, 32'h00);
        end
        $display("test taps done");
        apb(1'b1, IDX_IRQ_EN, 32'h0);
        apb(1'b1, IDX_TIMER_MODE, 32'h7);
        apb(1'b1, IDX_IRQ_REQ, 32'h0);
        apb(1'b1, IDX_COUNT, 32'hFF);
        repeat (16) @(posedge clock_in);
        #1 chk(overflow_irq_out, 1'b0);
        rdc(IDX_IRQ_REQ, 32'h1, 32'h1);
        apb(1'b1, IDX_IRQ_EN, 32'h1);
        settle();
        chk(overflow_irq_out, 1'b1);
        $display("test mask done");
        apb(1'b1, IDX_TIMER_MODE, 32'h87);
        apb(1'b1, IDX_IRQ_REQ, 32'h0);
        apb(1'b1, IDX_COUNT, 32'h80);
        wait_sig(0, 1'b1);
        t0 = t_mark;
        rdc(IDX_COUNT, 32'hFF, 32'h80);
        apb(1'b1, IDX_IRQ_REQ, 32'h0);
        wait_sig(0, 1'b1);
        chk(t_mark - t0, 128 * 8);
        $display("test reload done");
        apb(1'b1, IDX_PORT_FUNC, 32'h20);
        apb(1'b1, IDX_PIN_CTRL, 32'hC0);
        settle();
        chk({pin.irq_input_mode, pin.gpio_mode}, 2'b10);
        apb(1'b1, IDX_PORT_FUNC, 32'h0);
        apb(1'b1, IDX_PIN_CTRL, 32'h70);
        settle();
        chk({pin.irq_input_mode, pin.gpio_mode, pin.oe}, 3'b010);
        apb(1'b1, IDX_PIN_CTRL, 32'hB0);
        settle();
        chk({pin.gpio_mode, pin.oe, pin.level}, 3'b010);
        for (int f = 0; f < 2; f++) begin
            apb(1'b1, IDX_PIN_CTRL, f ? 32'hE0 : 32'hC0);
            halves();
            chk({pin.oe, 31'(hi)}, {1'b1, 31'(f ? 512 : 1024)});
            chk(lo, hi);
        end
        apb(1'b1, IDX_COUNT, 32'hFF);
        apb(1'b1, IDX_PIN_CTRL, 32'hF0);
        halves();
        chk(hi, 8);
        chk(lo, 8);
        $display("test pin done");
        end_of_test();
    end
endmodule
